// >>> hdl/vsync_gen.sv
// vertical sync pulse generator with composite sync output
// assumes sync_tip_in is high while the clamped input sits near the sync tip
module vsync_gen #(
    parameter logic [vsync_pkg::INTEG_W-1:0] LOWER_THRESHOLD   = vsync_pkg::LOWER_THRESHOLD_DEF,
    parameter logic [vsync_pkg::INTEG_W-1:0] DEFAULT_THRESHOLD =
        vsync_pkg::DEFAULT_THRESHOLD_DEF,
    parameter logic [vsync_pkg::INTEG_W-1:0] CHARGE_STEP       = vsync_pkg::CHARGE_STEP_DEF,
    parameter logic [vsync_pkg::OSC_W-1:0]   OSC_PERIOD        = vsync_pkg::OSC_PERIOD_DEF
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sync_tip_in,
    output logic      csync,
    output logic      vsync,
    output logic      field_parity
);
    import vsync_pkg::*;

    logic                 sync_act_r;
    logic                 sync_prev_r;
    logic [INTEG_W-1:0]   integ_r;
    logic                 lower_hit;
    logic                 default_hit;
    logic                 default_prev_r;
    logic                 default_rise_r;
    logic                 sample_r;
    logic                 set_req;
    logic                 vsync_r;
    logic [OSC_W-1:0]     osc_cnt_r;
    logic [DIV_W-1:0]     div_r;
    logic                 osc_tick;
    logic                 pulse_end;
    logic                 parity_r;
    logic                 sync_fall;

    // ***************************************
    // input and composite sync
    // ***************************************
    pin_sync3 u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .pin_in  (sync_tip_in),
        .level_r (sync_act_r)
    );

    assign csync = sync_act_r;  // [RQ13]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev_r <= 1'b0;
        end else begin
            sync_prev_r <= sync_act_r;
        end
    end

    assign sync_fall = sync_prev_r && !sync_act_r;

    // ***************************************
    // integrator
    // ***************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            integ_r <= '0;
        end else if (!sync_act_r) begin
            integ_r <= '0;                            // [RQ16]
        end else if (integ_r > INTEG_MAX - CHARGE_STEP) begin
            integ_r <= INTEG_MAX;                     // [RQ16]
        end else begin
            integ_r <= integ_r + CHARGE_STEP;         // [RQ1] [RQ9]
        end
    end

    // thresholds sit above line and equalising pulse lengths [RQ3]
    assign lower_hit   = (integ_r >= LOWER_THRESHOLD);    // [RQ2]
    assign default_hit = (integ_r >= DEFAULT_THRESHOLD);  // [RQ2]

    // ***************************************
    // sample flop and default edge
    // ***************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_r <= 1'b0;
        end else begin
            sample_r <= sync_fall && lower_hit;       // [RQ4] [RQ10] [RQ15]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            default_prev_r <= 1'b0;
            default_rise_r <= 1'b0;
        end else begin
            default_prev_r <= default_hit;
            default_rise_r <= default_hit && !default_prev_r;  // [RQ14]
        end
    end

    assign set_req = sample_r || default_rise_r;      // [RQ5] [RQ14]

    // ***************************************
    // oscillator and divide by eight
    // ***************************************
    assign osc_tick  = vsync_r && (osc_cnt_r == OSC_PERIOD - 16'h0001);
    assign pulse_end = osc_tick && (div_r == DIV_LAST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_r <= '0;
            div_r     <= '0;
        end else if (!vsync_r || (pulse_end && set_req)) begin
            osc_cnt_r <= '0;                          // [RQ6]
            div_r     <= '0;
        end else if (osc_tick) begin
            osc_cnt_r <= '0;
            div_r     <= div_r + 3'h1;                // [RQ7]
        end else begin
            osc_cnt_r <= osc_cnt_r + 16'h0001;        // [RQ9]
        end
    end

    // ***************************************
    // set/reset latch
    // ***************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vsync_r <= 1'b0;
        end else if (set_req && (!vsync_r || pulse_end)) begin
            vsync_r <= 1'b1;                          // [RQ5] [RQ11]
        end else if (pulse_end) begin
            vsync_r <= 1'b0;                          // [RQ7] [RQ8]
        end
    end

    assign vsync = vsync_r;  // [RQ8]

    // field parity flop clocked by latch set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            parity_r <= 1'b0;
        end else if (set_req && !vsync_r) begin
            parity_r <= ~parity_r;                    // [RQ6]
        end
    end

    assign field_parity = parity_r;

    // ***************************************
    // checks
    // ***************************************
    logic [INTEG_W-1:0] pw_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pw_r <= '0;
        end else if (!vsync_r || (pulse_end && set_req)) begin
            pw_r <= '0;
        end else begin
            pw_r <= pw_r + 16'h0001;
        end
    end

    property p_integ_clear;
        @(posedge clk) disable iff (!rst_n) !sync_act_r |=> integ_r == '0;
    endproperty
    a_integ_clear: assert property (p_integ_clear) else $error("integrator not cleared"); // [RQ16]

    property p_integ_grow;
        @(posedge clk) disable iff (!rst_n)
            sync_act_r && integ_r <= INTEG_MAX - CHARGE_STEP
            |=> integ_r == $past(integ_r) + CHARGE_STEP;
    endproperty
    a_integ_grow: assert property (p_integ_grow) else $error("integrator did not charge"); // [RQ1]

    property p_sample;
        @(posedge clk) disable iff (!rst_n) sync_fall && lower_hit |=> sample_r;
    endproperty
    a_sample: assert property (p_sample) else $error("serration edge not sampled"); // [RQ4]

    property p_no_pulse;
        @(posedge clk) disable iff (!rst_n)
            sync_fall && !lower_hit && !default_rise_r && !vsync_r |=> ##1 !vsync_r;
    endproperty
    a_no_pulse: assert property (p_no_pulse) else $error("pulse without threshold"); // [RQ10]

    property p_set;
        @(posedge clk) disable iff (!rst_n) sample_r |=> vsync_r;
    endproperty
    a_set: assert property (p_set) else $error("latch not set by sample"); // [RQ5]

    property p_default;
        @(posedge clk) disable iff (!rst_n) default_rise_r |=> vsync_r;
    endproperty
    a_default: assert property (p_default) else $error("default pulse missing"); // [RQ14]

    property p_width;
        @(posedge clk) disable iff (!rst_n)
            $fell(vsync_r) |-> $past(pw_r) == 8 * OSC_PERIOD - 1;
    endproperty
    a_width: assert property (p_width) else $error("vertical pulse width wrong"); // [RQ8]

    property p_parity;
        @(posedge clk) disable iff (!rst_n) $rose(vsync_r) |-> parity_r != $past(parity_r);
    endproperty
    a_parity: assert property (p_parity) else $error("parity flop not clocked"); // [RQ6]

    property p_osc_idle;
        @(posedge clk) disable iff (!rst_n)
            !vsync_r ##1 !vsync_r |-> osc_cnt_r == '0 && div_r == '0;
    endproperty
    a_osc_idle: assert property (p_osc_idle) else $error("oscillator runs while idle"); // [RQ7]

    property p_cov_serr;
        @(posedge clk) disable iff (!rst_n) sample_r ##1 vsync_r;
    endproperty
    c_cov_serr: cover property (p_cov_serr);

    property p_cov_default;
        @(posedge clk) disable iff (!rst_n) default_rise_r ##1 vsync_r;
    endproperty
    c_cov_default: cover property (p_cov_default);

    property p_cov_retrig;
        @(posedge clk) disable iff (!rst_n) $fell(vsync_r) ##[1:1000] $rose(vsync_r);
    endproperty
    c_cov_retrig: cover property (p_cov_retrig);
endmodule

// >>> hdl/vsync_pkg.sv
// constants for the vertical sync pulse generator
// assumes one 20 MHz clock and a sync level already cut by the analog slicer
// How it works
// (RQ1) the integrator charges only while the inverted sync level is active
// (RQ2) the integrator feeds a lower comparator and a default comparator at once
// (RQ3) line sync and equalising pulses are too short to reach the lower threshold
// (RQ4) each serration falling edge samples the lower comparator into the sample flop
// (RQ5) the sample flop sets the vertical latch through an or gate
// (RQ6) the set latch runs the oscillator and clocks the field parity flop
// (RQ7) a divide by eight on the oscillator clears the latch after eight cycles
// (RQ8) the latch is the vertical output, lasting eight oscillator cycles plus eight more for each set that lands on a pulse end
// (RQ9) oscillator period and charge rate are configuration parameters
// (RQ10) an integrator that never passes the lower threshold gives no vertical pulse
// (RQ11) a latch cleared early may be set again by a later serration edge
// (RQ12) the source holds each vertical sync pulse for at least 85% of a half line
// (RQ13) composite sync output reproduces the sliced sync level with video removed
// (RQ14) reaching the default threshold without a serration sets the latch
// (RQ15) a default pulse ended early is retriggered by the sync interval trailing edge
// (RQ16) the integrator is a saturating counter cleared outside sync
package vsync_pkg;
    // ***************************************
    // widths
    // ***************************************
    localparam int INTEG_W   = 16;
    localparam int OSC_W     = 16;
    localparam int DIV_W     = 3;
    localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;   // eight oscillator cycles
    localparam int DIV_COUNT = 8;
    localparam logic [INTEG_W-1:0] INTEG_MAX = 16'hFFFF;

    // ***************************************
    // timing
    // ***************************************
    localparam int CLK_PERIOD_NS    = 50;
    localparam int LOWER_TIME_NS    = 20000;
    localparam int DEFAULT_TIME_NS  = 65000;
    localparam int VPULSE_TIME_NS   = 230000;
    localparam int LOWER_CYC   = (LOWER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEFAULT_CYC = (DEFAULT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_CYC     = VPULSE_TIME_NS / (CLK_PERIOD_NS * DIV_COUNT);

    localparam logic [INTEG_W-1:0] LOWER_THRESHOLD_DEF   = INTEG_W'(LOWER_CYC);
    localparam logic [INTEG_W-1:0] DEFAULT_THRESHOLD_DEF = INTEG_W'(DEFAULT_CYC);
    localparam logic [INTEG_W-1:0] CHARGE_STEP_DEF       = 16'h0001;
    localparam logic [OSC_W-1:0]   OSC_PERIOD_DEF        = OSC_W'(OSC_CYC);
endpackage

// >>> hdl/pin_sync3.sv
// three flop input synchroniser with agreement filter
// assumes an asynchronous level input
module pin_sync3 (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      level_r
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // ***************************************
    // chain
    // ***************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // change counts once second and third agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end
endmodule

// >>> verification/sync_source.sv
// composite sync source model driving the sliced sync level
// assumes the bench clock; changes its output at the falling edge
module sync_source (
    input  wire logic clk,
    output logic      sync_tip_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // ***************************************
    // level driving
    // ***************************************
    initial sync_tip_in = 1'b0;

    // hold one level for a count of clocks
    task automatic hold(input logic lvl, input int cyc);
        @(negedge clk);
        sync_tip_in = lvl;
        repeat (cyc - 1) @(negedge clk);
    endtask

    // line or equalising sync pulses
    task automatic lines(input int n, input int width, input int gap);
        repeat (n) begin
            hold(1'b1, width);
            hold(1'b0, gap);
        end
    endtask

    // vertical sync well past half a line, then a serration
    task automatic vert(input int width, input int serr);
        hold(1'b1, width);
        hold(1'b0, serr);
    endtask
endmodule

// >>> verification/vsync_gen_tb_top.sv
// self-checking bench for the vertical sync pulse generator
// assumes the sync source model and short simulation thresholds
module vsync_gen_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import vsync_pkg::*;

    // ***************************************
    // setup
    // ***************************************
    localparam logic [INTEG_W-1:0] LOW_T = 16'h000A;
    localparam logic [INTEG_W-1:0] DEF_T = 16'h0028;
    localparam logic [OSC_W-1:0]   OSC_P = 16'h0003;
    localparam int                 WIDTH = DIV_COUNT * 3;

    logic clk;
    logic rst_n;
    logic sync_tip_in;
    logic csync;
    logic vsync;
    logic field_parity;
    logic exp_par;
    int   fails;
    int   total_checks;
    int   rises;
    int   cur_w;
    int   last_w;

    sync_source src (.clk(clk), .sync_tip_in(sync_tip_in));

    vsync_gen #(.LOWER_THRESHOLD(LOW_T), .DEFAULT_THRESHOLD(DEF_T),
                .CHARGE_STEP(16'h0001), .OSC_PERIOD(OSC_P)) dut (
        .clk          (clk),
        .rst_n        (rst_n),
        .sync_tip_in  (sync_tip_in),
        .csync        (csync),
        .vsync        (vsync),
        .field_parity (field_parity)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // pulse counter and width meter
    always @(posedge clk) begin
        if (vsync === 1'b1) begin
            cur_w <= cur_w + 1;
        end else if (cur_w != 0) begin
            last_w <= cur_w;
            rises  <= rises + 1;
            cur_w  <= 0;
        end
    end

    // ***************************************
    // helpers
    // ***************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic expect_pulses(input string name, input int n);
        src.hold(1'b0, 60);
        check("pulse count", n, rises);
        if (n > 0) check("pulse width", WIDTH, last_w);
        exp_par = exp_par ^ n[0];
        check("field parity", {31'h0, exp_par}, {31'h0, field_parity});
        rises = 0;
        $display("test %s done", name);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ***************************************
    // scenarios
    // ***************************************
    task automatic t_lines;
        src.hold(1'b1, 8);
        check("csync high", 1, {31'h0, csync});
        src.hold(1'b0, 20);
        check("csync low", 0, {31'h0, csync});
        src.lines(6, 5, 20);
        src.lines(6, 2, 9);
        expect_pulses("lines", 0);
    endtask

    task automatic t_serration;
        src.vert(20, 3);
        src.vert(20, 3);
        expect_pulses("serration", 1);
    endtask

    task automatic t_retrigger;
        repeat (3) src.vert(27, 3);
        expect_pulses("retrigger", 3);
    endtask

    task automatic t_default;
        src.vert(100, 3);
        expect_pulses("default", 2);
    endtask

    // ***************************************
    // main sequence
    // ***************************************
    initial begin
        rst_n        = 1'b0;
        exp_par      = 1'b0;
        fails        = 0;
        total_checks = 0;
        rises        = 0;
        cur_w        = 0;
        last_w       = 0;
        repeat (5) @(negedge clk);
        check("vsync in reset", 0, {31'h0, vsync});
        rst_n = 1'b1;
        t_lines();
        t_serration();
        t_retrigger();
        t_default();
        test_done();
    end

    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        test_done();
    end
endmodule
